// [logic/sdram_pin_device.sv]
`include "sdram_pin_map.svh"

// Function
// R1 - Inputs sampled only on rising clock
// R2 - Clock gate low freezes internal state
// R3 - Deselect ignores commands, bursts continue
// R4 - Three strobes select the command
// R5 - Activate captures thirteen-bit row address
// R6 - Read/write take nine column bits
// R7 - Auto-precharge flag closes bank after burst
// R8 - Precharge flag high closes all banks
// R9 - Bank select picks the target bank
// R10 - Mask high tristates data lanes
// R11 - Read mask acts with two-cycle latency
// R12 - Write mask zero latency blocks lane
// R13 - Strobe encodings per command listed
// R14 - Controller keeps gate high during bursts (the code holds it high for read bursts only)
// R15 - Mask bit n governs lane n
// R16 - Controller deselects or NOPs when idle
module sdram_pin_device #(
	parameter int COL_W = `COL_BITS,
	parameter int BURST = `BURST_LEN
)
(
	// Clock and reset
	input  wire logic                    mclk_i,
	input  wire logic                    arst_n_i,
	// Pin side
	sdram_pin_if.dev                     pins,
	// Status
	output logic [3:0]                   bank_open_o,
	output logic [`ROW_BITS-1:0]         last_row_o
);
	import sdram_pin_pkg::*;

	// The core array is a window of the full space: bank, column and one row bit.
	localparam int IDX_W = `BANK_BITS + COL_W + 1;

	// Everything the device remembers between edges, apart from the array itself.
	typedef struct packed {
		logic [3:0]                 open;
		logic [3:0][`ROW_BITS-1:0] row;
		logic [`ROW_BITS-1:0]      last_row;
		logic                       rd_act;
		logic                       wr_act;
		logic [7:0]                 left;
		bank_t                      bank;
		logic [COL_W-1:0]          col;
		logic                       ap;
		logic [`READ_LATENCY:0]    rd_pipe;
		mask_t [`MASK_RD_LATENCY:0] mask_pipe;
		word_t [`READ_LATENCY-1:0]  dpipe;
		word_t                      dout;
		mask_t                      oe;
	} state_s;

	state_s             s_q;
	state_s             s_d;
	cmd_e               cmd;
	word_t              mem [1 << IDX_W];
	logic [IDX_W-1:0]   rd_idx;
	logic [IDX_W-1:0]   wr_idx;
	logic [IDX_W-1:0]   cmd_idx;
	logic [IDX_W-1:0]   wr_addr;
	logic               wr_en;
	logic               wr_first;
	logic [`LANES-1:0]  lane_we;

	// Only the lowest row bit reaches the window, so higher row bits alias.
	// That keeps the model small at the cost of not telling far rows apart.
	assign rd_idx  = {s_q.bank, s_q.col, 1'b0}
		^ {s_q.row[s_q.bank][0], (IDX_W-1)'(0)};
	assign wr_idx  = rd_idx;
	assign cmd_idx = {pins.bank_select, pins.address_lines[COL_W-1:0], 1'b0}
		^ {s_q.row[pins.bank_select][0], (IDX_W-1)'(0)}; // R6 R9

	// A deselected decoder turns every strobe pattern into no operation, while a burst
	// that is already running keeps counting in the state logic below.
	always_comb
	begin
		cmd = CMD_NOP;
		if (!pins.device_select_n) // R3
		begin
			case ({pins.row_strobe_n, pins.column_strobe_n, pins.write_strobe_n}) // R4 R13
				3'b011:  cmd = CMD_ACTIVATE;
				3'b101:  cmd = CMD_READ;
				3'b100:  cmd = CMD_WRITE;
				3'b010:  cmd = CMD_PRECHARGE;
				3'b000:  cmd = CMD_MODE_SET;
				3'b001:  cmd = CMD_REFRESH;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	always_comb
	begin
		s_d = s_q;
		wr_en = 1'b0;
		// With the gate low nothing advances: the array, the pipes and the burst all hold.
		if (pins.clock_gate_input) // R2
		begin
			s_d.rd_pipe   = {s_q.rd_pipe[`READ_LATENCY-1:0], s_q.rd_act};
			s_d.mask_pipe = {s_q.mask_pipe[`MASK_RD_LATENCY-1:0], pins.byte_mask}; // R11
			// Two stages of array output keep each beat level with its read pipe bit.
			s_d.dpipe     = {s_q.dpipe[`READ_LATENCY-2:0], mem[rd_idx]};
			s_d.dout      = s_q.dpipe[`READ_LATENCY-1];
			// The enable follows the read pipe and the mask sampled two edges back.
			s_d.oe        = s_q.rd_pipe[`READ_LATENCY-1] ? ~s_q.mask_pipe[`MASK_RD_LATENCY-1]
				: 4'h0; // R10 R11 R15
			if (s_q.rd_act || s_q.wr_act)
			begin
				wr_en = s_q.wr_act; // R12
				s_d.col = s_q.col + 1'b1;
				s_d.left = s_q.left - 8'h01;
				if (s_q.left == 8'h01)
				begin
					s_d.rd_act = 1'b0;
					s_d.wr_act = 1'b0;
					if (s_q.ap)
						s_d.open[s_q.bank] = 1'b0; // R7
				end
			end
			case (cmd)
				CMD_ACTIVATE:
				begin
					s_d.open[pins.bank_select] = 1'b1; // R9
					s_d.row[pins.bank_select] = pins.address_lines; // R5
					s_d.last_row = pins.address_lines;
				end
				CMD_READ:
				begin
					s_d.bank   = pins.bank_select; // R9
					s_d.col    = pins.address_lines[COL_W-1:0]; // R6
					s_d.ap     = pins.address_lines[`AP_BIT]; // R7
					s_d.left   = 8'(BURST);
					s_d.rd_act = 1'b1;
					s_d.wr_act = 1'b0;
				end
				CMD_WRITE:
				begin
					// The first beat is stored with the command, so the burst resumes one column on.
					s_d.bank   = pins.bank_select; // R9
					s_d.col    = pins.address_lines[COL_W-1:0] + 1'b1; // R6
					s_d.ap     = pins.address_lines[`AP_BIT]; // R7
					s_d.left   = 8'(BURST - 1);
					s_d.rd_act = 1'b0;
					s_d.wr_act = (BURST > 1);
					if (BURST == 1 && pins.address_lines[`AP_BIT])
						s_d.open[pins.bank_select] = 1'b0; // R7
				end
				CMD_MODE_SET, CMD_REFRESH:
				begin
					// Neither touches the open rows or a running burst in this model.
				end
				CMD_PRECHARGE:
				begin
					// The flag high closes every bank; otherwise only the named one.
					if (pins.address_lines[`AP_BIT])
						s_d.open = 4'h0; // R8
					else
						s_d.open[pins.bank_select] = 1'b0; // R8
				end
				default:
				begin
				end
			endcase
		end
	end

	// Reset closes all banks and turns the data drivers off.
	always_ff @(posedge mclk_i or negedge arst_n_i) // R1
	begin
		if (!arst_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// The first write beat rides with the command; later beats follow it.
	assign wr_first = pins.clock_gate_input && (cmd == CMD_WRITE);
	assign wr_addr  = wr_first ? cmd_idx : wr_idx;

	// A lane stores its byte only while its mask is low; a masked lane keeps its old byte.
	generate
		for (genvar g = 0; g < `LANES; g++)
		begin : g_lane
			assign lane_we[g] = (wr_first || wr_en) && !pins.byte_mask[g]; // R12 R15
		end
	endgenerate

	always_ff @(posedge mclk_i)
	begin
		for (int i = 0; i < `LANES; i++)
		begin
			if (lane_we[i])
				mem[wr_addr][8*i +: 8] <= pins.data_io[8*i +: 8]; // R1
		end
	end

	// Outputs come straight from the state register, so the bus changes only after an edge.
	assign pins.data_dev_o  = s_q.dout;
	assign pins.data_dev_oe = s_q.oe;
	assign bank_open_o      = s_q.open;
	assign last_row_o       = s_q.last_row;
endmodule

// [logic/sdram_pin_map.svh]
`ifndef SDRAM_PIN_MAP_SVH
`define SDRAM_PIN_MAP_SVH

`define ROW_BITS        13
`define COL_BITS        9
`define BANK_BITS       2
`define LANES           4
`define AP_BIT          10
`define READ_LATENCY    2
`define MASK_RD_LATENCY 2
`define BURST_LEN       4
`define FIFO_DEPTH      32

`endif

// [logic/sdram_pin_pkg.sv]
package sdram_pin_pkg;

	typedef enum logic [2:0]
	{
		CMD_NOP,
		CMD_ACTIVATE,
		CMD_READ,
		CMD_WRITE,
		CMD_PRECHARGE,
		CMD_MODE_SET,
		CMD_REFRESH
	} cmd_e;

	typedef logic [31:0] word_t;
	typedef logic [12:0] addr_t;
	typedef logic [1:0]  bank_t;
	typedef logic [3:0]  mask_t;

endpackage

// [logic/sdram_pin_if.sv]
interface sdram_pin_if;
	import sdram_pin_pkg::*;

	logic  clock_gate_input;
	logic  device_select_n;
	logic  row_strobe_n;
	logic  column_strobe_n;
	logic  write_strobe_n;
	addr_t address_lines;
	bank_t bank_select;
	mask_t byte_mask;
	word_t data_ctl_o;
	mask_t data_ctl_oe;
	word_t data_dev_o;
	mask_t data_dev_oe;
	word_t data_io;

	// Each lane of the shared bus resolves from whichever side enables it.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (data_dev_oe[i])
				data_io[8*i +: 8] = data_dev_o[8*i +: 8];
			else if (data_ctl_oe[i])
				data_io[8*i +: 8] = data_ctl_o[8*i +: 8];
			else
				data_io[8*i +: 8] = 8'h00;
		end
	end

	modport dev
	(
		input  clock_gate_input, device_select_n, row_strobe_n, column_strobe_n,
		input  write_strobe_n, address_lines, bank_select, byte_mask, data_io,
		output data_dev_o, data_dev_oe
	);

	modport ctl
	(
		output clock_gate_input, device_select_n, row_strobe_n, column_strobe_n,
		output write_strobe_n, address_lines, bank_select, byte_mask, data_ctl_o,
		output data_ctl_oe,
		input  data_io
	);
endinterface

// [logic/sync_fifo.sv]
module sync_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
)
(
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             arst_n_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem[rd_q];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem[wr_q] <= in_data_i;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [logic/sdram_pin_controller.sv]
`include "sdram_pin_map.svh"

module sdram_pin_controller #(
	parameter int DEPTH = `FIFO_DEPTH
)
(
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  arst_n_i,
	// Command request
	input  wire logic                  req_valid_i,
	output logic                       req_ready_o,
	input  wire sdram_pin_pkg::cmd_e   req_cmd_i,
	input  wire sdram_pin_pkg::addr_t  req_addr_i,
	input  wire sdram_pin_pkg::bank_t  req_bank_i,
	input  wire sdram_pin_pkg::mask_t  req_mask_i,
	input  wire sdram_pin_pkg::word_t  req_data_i,
	input  wire logic                  clock_gate_i,
	// Read data out
	output logic                       rd_valid_o,
	input  wire logic                  rd_ready_i,
	output sdram_pin_pkg::word_t       rd_data_o,
	// Pin side
	sdram_pin_if.ctl                   pins
);
	import sdram_pin_pkg::*;

	typedef struct packed {
		logic  ncs;
		logic  nras;
		logic  ncas;
		logic  nwe;
		addr_t addr;
		bank_t bank;
		mask_t mask;
		word_t dout;
		mask_t oe;
		logic  cke;
		logic [`READ_LATENCY+`BURST_LEN+1:0] rd_pipe;
	} state_s;

	state_s s_q;
	state_s s_d;
	logic   rd_cap;
	logic   fifo_in_ready;

	// A request is taken only when the read FIFO can hold a reply.
	assign req_ready_o = fifo_in_ready;
	// The first beat stands on the pins three cycles after the device registers the read.
	// The pipe runs on to the end of the burst so that the gate stays high until then.
	assign rd_cap      = s_q.rd_pipe[`READ_LATENCY+2];

	always_comb
	begin
		s_d = s_q;
		s_d.ncs  = 1'b1; // R16
		s_d.nras = 1'b1;
		s_d.ncas = 1'b1;
		s_d.nwe  = 1'b1;
		s_d.oe   = 4'h0;
		s_d.cke  = clock_gate_i || (s_q.rd_pipe != '0); // R14
		s_d.rd_pipe = {s_q.rd_pipe[`READ_LATENCY+`BURST_LEN:0], 1'b0};
		if (req_valid_i && req_ready_o)
		begin
			s_d.ncs  = 1'b0;
			s_d.addr = req_addr_i;
			s_d.bank = req_bank_i;
			s_d.mask = req_mask_i;
			case (req_cmd_i) // R13
				CMD_ACTIVATE:  {s_d.nras, s_d.ncas, s_d.nwe} = 3'b011;
				CMD_READ:
				begin
					{s_d.nras, s_d.ncas, s_d.nwe} = 3'b101;
					s_d.rd_pipe[0] = 1'b1;
				end
				CMD_WRITE:
				begin
					{s_d.nras, s_d.ncas, s_d.nwe} = 3'b100;
					s_d.dout = req_data_i;
					s_d.oe   = 4'hf;
				end
				CMD_PRECHARGE: {s_d.nras, s_d.ncas, s_d.nwe} = 3'b010;
				CMD_MODE_SET:  {s_d.nras, s_d.ncas, s_d.nwe} = 3'b000;
				CMD_REFRESH:   {s_d.nras, s_d.ncas, s_d.nwe} = 3'b001;
				default:       {s_d.nras, s_d.ncas, s_d.nwe} = 3'b111;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_q      <= '0;
			s_q.ncs  <= 1'b1;
			s_q.nras <= 1'b1;
			s_q.ncas <= 1'b1;
			s_q.nwe  <= 1'b1;
			s_q.mask <= 4'hf;
			s_q.cke  <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	sync_fifo #(.WIDTH(32), .DEPTH(DEPTH)) rd_fifo
	(
		.mclk_i      (mclk_i),
		.arst_n_i    (arst_n_i),
		.in_valid_i  (rd_cap),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (pins.data_io),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);

	assign pins.clock_gate_input = s_q.cke;
	assign pins.device_select_n  = s_q.ncs;
	assign pins.row_strobe_n     = s_q.nras;
	assign pins.column_strobe_n  = s_q.ncas;
	assign pins.write_strobe_n   = s_q.nwe;
	assign pins.address_lines    = s_q.addr;
	assign pins.bank_select      = s_q.bank;
	assign pins.byte_mask        = s_q.mask;
	assign pins.data_ctl_o       = s_q.dout;
	assign pins.data_ctl_oe      = s_q.oe;
endmodule

// [tb/sdram_pin_asserts.sv]
module sdram_pin_asserts
(
	// Pins
	input wire logic                 mclk_i,
	input wire logic                 arst_n_i,
	input wire logic                 clock_gate_input,
	input wire logic                 device_select_n,
	input wire logic                 row_strobe_n,
	input wire logic                 column_strobe_n,
	input wire logic                 write_strobe_n,
	input wire sdram_pin_pkg::mask_t byte_mask,
	input wire sdram_pin_pkg::mask_t data_ctl_oe,
	input wire sdram_pin_pkg::mask_t data_dev_oe
);
	import sdram_pin_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic sel;
	logic rd_cmd;
	logic wr_cmd;
	// A command only counts while the clock runs and the decoder is selected.
	assign sel = clock_gate_input && !device_select_n;
	assign rd_cmd = sel && row_strobe_n && !column_strobe_n && write_strobe_n;
	assign wr_cmd = sel && row_strobe_n && !column_strobe_n && !write_strobe_n;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	reset_idle_a: assert property ($rose(arst_n_i) |-> device_select_n && byte_mask == 4'hf)
		else $error("pins busy after reset");
	cmd_single_a: assert property (!device_select_n |=> device_select_n)
		else $error("command held");
	no_fight_a: assert property ((data_dev_oe & data_ctl_oe) == 4'h0)
		else $error("both drive a lane");
	oe_cause_a: assert property (data_dev_oe != 4'h0 |-> (data_dev_oe & $past(byte_mask, 3)) == 4'h0)
		else $error("masked lane driven");
	read_oe_a: assert property (rd_cmd |-> ##4 data_dev_oe == ~$past(byte_mask, 3))
		else $error("read enable wrong");
	read_end_a: assert property (rd_cmd ##1 device_select_n [*7] |=> data_dev_oe == 4'h0)
		else $error("burst too long");
	gate_burst_a: assert property ($fell(clock_gate_input) |-> data_dev_oe == 4'h0)
		else $error("gate low in burst");
	ctl_beat_a: assert property (data_ctl_oe != 4'h0 |-> wr_cmd)
		else $error("stray write drive");
endmodule

// [tb/tb_sdram_pin_command_interface.sv]
module tb_sdram_pin_command_interface import sdram_pin_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk_i;
	logic       arst_n_i;
	logic       req_valid_i;
	logic       req_ready_o;
	cmd_e       req_cmd_i;
	addr_t      req_addr_i;
	bank_t      req_bank_i;
	mask_t      req_mask_i;
	word_t      req_data_i;
	logic       clock_gate_i;
	logic       rd_valid_o;
	logic       rd_ready_i;
	word_t      rd_data_o;
	logic [3:0] bank_open_o;
	addr_t      last_row_o;
	word_t      d;
	int         fail_count;
	int         num_checks;
	int         cyc;
	int         n;
	bit         strict;
	bit         t;

	sdram_pin_if sdram_pin_if_i ();
	sdram_pin_controller sdram_pin_controller_i (.mclk_i, .arst_n_i, .req_valid_i, .req_ready_o,
		.req_cmd_i, .req_addr_i, .req_bank_i, .req_mask_i, .req_data_i, .clock_gate_i,
		.rd_valid_o, .rd_ready_i, .rd_data_o, .pins(sdram_pin_if_i));
	sdram_pin_device sdram_pin_device_i (.mclk_i, .arst_n_i, .pins(sdram_pin_if_i),
		.bank_open_o, .last_row_o);
	sdram_pin_asserts sdram_pin_asserts_i (.mclk_i, .arst_n_i,
		.clock_gate_input(sdram_pin_if_i.clock_gate_input),
		.device_select_n(sdram_pin_if_i.device_select_n),
		.row_strobe_n(sdram_pin_if_i.row_strobe_n),
		.column_strobe_n(sdram_pin_if_i.column_strobe_n),
		.write_strobe_n(sdram_pin_if_i.write_strobe_n), .byte_mask(sdram_pin_if_i.byte_mask),
		.data_ctl_oe(sdram_pin_if_i.data_ctl_oe), .data_dev_oe(sdram_pin_if_i.data_dev_oe));

	initial
	begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic check(input word_t seen, input word_t exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h not %h", $time, seen, exp);
		end
	endtask

	// Valid stays up until ready was seen at a falling edge, so the next rising edge takes it.
	task automatic req(input cmd_e c, input addr_t a, input bank_t b, input mask_t k, input word_t w);
		int i;
		i = 0;
		req_cmd_i = c;
		req_addr_i = a;
		req_bank_i = b;
		req_mask_i = k;
		req_data_i = w;
		req_valid_i = 1'b1;
		while (req_ready_o !== 1'b1 && i < 50)
		begin
			i++;
			@(negedge mclk_i);
		end
		t = i < 50;
		@(negedge mclk_i);
		req_valid_i = 1'b0;
		if (strict)
			check(word_t'(t), 32'h1);
		repeat (10) @(negedge mclk_i);
	endtask

	task automatic get();
		int i;
		i = 0;
		while (rd_valid_o !== 1'b1 && i < 20)
		begin
			i++;
			@(negedge mclk_i);
		end
		t = i < 20;
		d = rd_data_o;
		rd_ready_i = 1'b1;
		@(negedge mclk_i);
		rd_ready_i = 1'b0;
		if (strict)
			check(word_t'(t), 32'h1);
	endtask

	initial
	begin
		arst_n_i = 1'b0;
		req_valid_i = 1'b0;
		req_cmd_i = CMD_NOP;
		req_addr_i = 13'h0000;
		req_bank_i = 2'h0;
		req_mask_i = 4'h0;
		req_data_i = 32'h0;
		clock_gate_i = 1'b1;
		rd_ready_i = 1'b0;
		strict = 1'b1;
		repeat (3) @(negedge mclk_i);
		arst_n_i = 1'b1;
		req(CMD_NOP, 13'h0000, 2'h0, 4'h0, 32'h0);
		req(CMD_MODE_SET, 13'h0000, 2'h0, 4'h0, 32'h0);
		req(CMD_REFRESH, 13'h0000, 2'h0, 4'h0, 32'h0);
		check(word_t'(bank_open_o), 32'h0);
		req(CMD_ACTIVATE, 13'h1abc, 2'h1, 4'h0, 32'h0);
		check(word_t'(last_row_o), 32'h1abc);
		check(word_t'(bank_open_o), 32'h2);
		req(CMD_WRITE, 13'h0005, 2'h1, 4'h0, 32'h11223344);
		req(CMD_WRITE, 13'h0005, 2'h1, 4'h5, 32'haabbccdd);
		req(CMD_READ, 13'h0005, 2'h1, 4'h0, 32'h0);
		get();
		check(d, 32'haa22cc44);
		req(CMD_READ, 13'h1205, 2'h1, 4'h3, 32'h0);
		get();
		check(d, 32'haa220000);
		// The gate is the only way to stop the device, so a command sent meanwhile must not land.
		strict = 1'b0;
		clock_gate_i = 1'b0;
		req(CMD_ACTIVATE, 13'h0007, 2'h2, 4'h0, 32'h0);
		check(word_t'(bank_open_o), 32'h2);
		clock_gate_i = 1'b1;
		strict = 1'b1;
		req(CMD_ACTIVATE, 13'h0007, 2'h2, 4'h0, 32'h0);
		req(CMD_PRECHARGE, 13'h0000, 2'h1, 4'h0, 32'h0);
		check(word_t'(bank_open_o), 32'h4);
		req(CMD_ACTIVATE, 13'h0003, 2'h3, 4'h0, 32'h0);
		req(CMD_READ, 13'h0405, 2'h3, 4'h0, 32'h0);
		get();
		check(word_t'(bank_open_o), 32'h4);
		req(CMD_PRECHARGE, 13'h0400, 2'h0, 4'h0, 32'h0);
		check(word_t'(bank_open_o), 32'h0);
		req(CMD_ACTIVATE, 13'h0000, 2'h0, 4'h0, 32'h0);
		strict = 1'b0;
		repeat (34)
		begin
			req(CMD_READ, 13'h0000, 2'h0, 4'h0, 32'h0);
			n += t;
		end
		check(word_t'(n), 32'd32);
		n = 0;
		repeat (34)
		begin
			get();
			n += t;
		end
		check(word_t'(n), 32'd32);
		report_and_stop();
	end
endmodule
